// >>> design/rcsl_top.sv
// remote contact inputs, mode control, serial line link, bcd source
// assumes remote inputs and serial pins are asynchronous, measurement
// values arrive on sys_clk, and software sits on an AHB-Lite bus
`default_nettype none
module rcsl_top #(
  parameter int CLK_HZ     = 125000000,  // system clock rate
  parameter int LINE_DEPTH = 64,         // line buffer characters
  parameter int BCD_W      = 24          // parallel bcd width
) (
  input  wire logic             sys_clk,              // 125 MHz clock
  input  wire logic             nrst,                 // sync reset, low
  input  wire logic             hsel,                 // ahb select
  input  wire logic [31:0]      haddr,                // ahb address
  input  wire logic [1:0]       htrans,               // ahb transfer type
  input  wire logic             hwrite,               // ahb write
  input  wire logic [2:0]       hsize,                // ahb size
  input  wire logic [31:0]      hwdata,               // ahb write data
  input  wire logic             hready,               // ahb bus ready
  output logic [31:0]           hrdata,               // ahb read data
  output logic                  hreadyout,            // ahb slave ready
  output logic                  hresp,                // ahb response
  input  wire logic             remote_start,         // remote start pin
  input  wire logic             remote_stop,          // remote stop pin
  input  wire logic             remote_pause,         // remote pause pin
  input  wire logic             reference_calibrate_input, // cal pin
  output logic                  running_status,       // calc or suspend
  output logic                  cal_pulse,            // calibration strobe
  input  wire logic             rxd,                  // serial in
  output logic                  txd,                  // serial out
  input  wire logic             cts_n,                // host ready, low
  output logic                  rts_n,                // we accept, low
  input  wire logic [BCD_W-1:0] thickness_result,     // thickness value
  input  wire logic [BCD_W-1:0] gap_a,                // gap a value
  input  wire logic [BCD_W-1:0] gap_b,                // gap b value
  input  wire logic             meas_update,          // new values pulse
  output logic [BCD_W-1:0]      bcd_data,             // parallel output
  output logic                  parallel_data_valid   // bcd data valid
);
  localparam int IDX_W = $clog2(LINE_DEPTH);

  // divisor for the 16x enable, rounded to nearest
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int bps;
    bps = rcsl_pkg::BAUD_2;
    case (sel)
      3'h0:    bps = rcsl_pkg::BAUD_0;
      3'h1:    bps = rcsl_pkg::BAUD_1;
      3'h2:    bps = rcsl_pkg::BAUD_2;
      3'h3:    bps = rcsl_pkg::BAUD_3;
      3'h4:    bps = rcsl_pkg::BAUD_4;
      default: bps = rcsl_pkg::BAUD_2;
    endcase
    return 16'((CLK_HZ + bps * rcsl_pkg::OVERSAMPLE / 2)
               / (bps * rcsl_pkg::OVERSAMPLE));
  endfunction

  function automatic logic is_reg(input logic [31:0] a,
                                  input logic [11:0] off);
    return a[11:0] == off;
  endfunction

  logic [31:0]       ctrl_reg;
  logic [2:0]        baud_sel;
  logic [1:0]        src_sel;
  logic              cond_mode;
  rcsl_pkg::rcsl_mode_t  mode_reg;
  rcsl_pkg::rcsl_txseq_t txseq_reg;
  logic [15:0]       div_cnt_reg;
  logic              tick16_reg;
  logic [3:0]        pin_s1_reg;
  logic [3:0]        pin_s2_reg;
  logic [3:0]        pin_prev_reg;
  logic [3:0]        pin_edge;
  logic [1:0]        ser_s1_reg;
  logic [1:0]        ser_s2_reg;
  logic              ap_valid_reg;
  logic              ap_write_reg;
  logic [31:0]       ap_addr_reg;
  logic              ap_take;
  logic              wr_ctrl;
  logic              wr_status;
  logic              wr_tx;
  logic              wr_keys;
  logic [3:0]        sw_key;
  logic              ev_start;
  logic              ev_stop;
  logic              ev_pause;
  logic              ev_cal;
  logic [15:0]       cal_cnt_reg;
  logic [7:0]        line_mem [LINE_DEPTH];
  logic [IDX_W:0]    wr_ptr_reg;
  logic [7:0]        last_ch_reg;
  logic              line_ready_reg;
  logic [7:0]        line_len_reg;
  logic              ferr_reg;
  logic              ovf_reg;
  logic [7:0]        tx_hold_reg;
  logic              tx_eol_reg;
  logic              tx_start_reg;
  logic [7:0]        tx_byte_reg;
  logic              tx_busy;
  logic              rx_valid;
  logic [7:0]        rx_byte;
  logic              rx_ferr;
  logic              line_done;
  logic [31:0]       status_word;
  logic [31:0]       rd_word;

  assign baud_sel  = ctrl_reg[rcsl_pkg::CTRL_BAUD_LSB +: 3];
  assign src_sel   = ctrl_reg[rcsl_pkg::CTRL_SRC_LSB +: 2];
  assign cond_mode = ctrl_reg[rcsl_pkg::CTRL_COND_BIT];

  // address phase captured, write data used in the following cycle
  assign ap_take   = hsel && htrans[1] && hready;
  assign wr_ctrl   = ap_valid_reg && ap_write_reg
                     && is_reg(ap_addr_reg, rcsl_pkg::OFF_CTRL);
  assign wr_status = ap_valid_reg && ap_write_reg
                     && is_reg(ap_addr_reg, rcsl_pkg::OFF_STATUS);
  assign wr_tx     = ap_valid_reg && ap_write_reg
                     && is_reg(ap_addr_reg, rcsl_pkg::OFF_TXDATA);
  assign wr_keys   = ap_valid_reg && ap_write_reg
                     && is_reg(ap_addr_reg, rcsl_pkg::OFF_KEYS);
  assign sw_key    = wr_keys ? hwdata[3:0] : 4'h0;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg  <= 32'h0000_0000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end else begin
      ap_valid_reg <= ap_take;
      ap_write_reg <= hwrite;
      ap_addr_reg  <= haddr;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_reg <= rcsl_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= {26'h0, hwdata[5:0]};
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[rcsl_pkg::ST_MODE_LSB +: 2]  = mode_reg;
    status_word[rcsl_pkg::ST_RUN_BIT]        = running_status;
    status_word[rcsl_pkg::ST_LINE_BIT]       = line_ready_reg;
    status_word[rcsl_pkg::ST_TXBUSY_BIT]     =
      txseq_reg != rcsl_pkg::RCSL_TX_IDLE;
    status_word[rcsl_pkg::ST_FERR_BIT]       = ferr_reg;
    status_word[rcsl_pkg::ST_OVF_BIT]        = ovf_reg;
    status_word[rcsl_pkg::ST_LEN_LSB +: 8]   = line_len_reg;
  end

  // read data registered at the address phase: zero wait states
  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr[rcsl_pkg::BUF_BIT]) begin
      rd_word = {24'h0, line_mem[haddr[IDX_W+1:2]]};
    end else if (is_reg(haddr, rcsl_pkg::OFF_CTRL)) begin
      rd_word = ctrl_reg;
    end else if (is_reg(haddr, rcsl_pkg::OFF_STATUS)) begin
      rd_word = status_word;
    end else if (is_reg(haddr, rcsl_pkg::OFF_CALCNT)) begin
      rd_word = {16'h0, cal_cnt_reg};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_take && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // remote pins are conditioned outside, so no debounce here
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_s1_reg   <= 4'h0;
      pin_s2_reg   <= 4'h0;
      pin_prev_reg <= 4'h0;
      ser_s1_reg   <= 2'h3;
      ser_s2_reg   <= 2'h3;
    end else begin
      pin_s1_reg   <= {reference_calibrate_input, remote_pause,
                       remote_stop, remote_start};
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
      ser_s1_reg   <= {cts_n, rxd};
      ser_s2_reg   <= ser_s1_reg;
    end
  end

  // only the rising edge counts; a held level does nothing more
  assign pin_edge = pin_s2_reg & ~pin_prev_reg;
  assign ev_start = pin_edge[0] || sw_key[rcsl_pkg::KEY_START_BIT];
  assign ev_stop  = pin_edge[1] || sw_key[rcsl_pkg::KEY_STOP_BIT];
  assign ev_pause = pin_edge[2] || sw_key[rcsl_pkg::KEY_PAUSE_BIT];
  assign ev_cal   = pin_edge[3] || sw_key[rcsl_pkg::KEY_CAL_BIT];

  // stop outranks start and pause; in calc start is ignored, in suspend either one resumes calc
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mode_reg <= rcsl_pkg::RCSL_MEASURE;
    end else begin
      case (mode_reg)
        rcsl_pkg::RCSL_MEASURE: begin
          if (ev_start && !ev_stop) begin
            mode_reg <= rcsl_pkg::RCSL_CALC;
          end
        end
        rcsl_pkg::RCSL_CALC: begin
          if (ev_stop) begin
            mode_reg <= rcsl_pkg::RCSL_MEASURE;
          end else if (ev_pause) begin
            mode_reg <= rcsl_pkg::RCSL_SUSPEND;
          end
        end
        rcsl_pkg::RCSL_SUSPEND: begin
          if (ev_stop) begin
            mode_reg <= rcsl_pkg::RCSL_MEASURE;
          end else if (ev_pause || ev_start) begin
            mode_reg <= rcsl_pkg::RCSL_CALC;
          end
        end
        default: mode_reg <= rcsl_pkg::RCSL_MEASURE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      running_status <= 1'b0;
    end else begin
      running_status <= ev_stop ? 1'b0 :
        (mode_reg != rcsl_pkg::RCSL_MEASURE) || (ev_start && !ev_stop);
    end
  end

  // calibration strobes and counts; the stored reference thickness is outside
  // and never written from here
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cal_pulse   <= 1'b0;
      cal_cnt_reg <= 16'h0000;
    end else begin
      cal_pulse <= ev_cal && cond_mode
                   && mode_reg == rcsl_pkg::RCSL_MEASURE;
      if (ev_cal && cond_mode
          && mode_reg == rcsl_pkg::RCSL_MEASURE) begin
        cal_cnt_reg <= cal_cnt_reg + 16'h0001;
      end
    end
  end

  // valid drops for one cycle and rises on the same edge that loads the new bcd data
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bcd_data            <= '0;
      parallel_data_valid <= 1'b0;
    end else if (meas_update || wr_ctrl) begin
      parallel_data_valid <= 1'b0;
    end else if (!parallel_data_valid) begin
      parallel_data_valid <= 1'b1;
      case (src_sel)
        rcsl_pkg::SRC_THICKNESS_RESULT: bcd_data <= thickness_result;
        rcsl_pkg::SRC_GAP_A: bcd_data <= gap_a;
        rcsl_pkg::SRC_GAP_B: bcd_data <= gap_b;
        default:             bcd_data <= thickness_result;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_cnt_reg <= 16'h0000;
      tick16_reg  <= 1'b0;
    end else if (div_cnt_reg + 16'h0001 >= baud_div(baud_sel)) begin
      div_cnt_reg <= 16'h0000;
      tick16_reg  <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
      tick16_reg  <= 1'b0;
    end
  end

  rcsl_uart u_uart (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .tick16   (tick16_reg),
    .rxd_s    (ser_s2_reg[0]),
    .tx_start (tx_start_reg),
    .tx_byte  (tx_byte_reg),
    .tx_busy  (tx_busy),
    .txd      (txd),
    .rx_valid (rx_valid),
    .rx_byte  (rx_byte),
    .rx_ferr  (rx_ferr)
  );

  assign line_done = rx_valid && !line_ready_reg
                     && rx_byte == rcsl_pkg::CHAR_LF
                     && last_ch_reg == rcsl_pkg::CHAR_CR;

  // line is held until software clears it; a new line wins the clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wr_ptr_reg     <= '0;
      last_ch_reg    <= 8'h00;
      line_ready_reg <= 1'b0;
      line_len_reg   <= 8'h00;
      ferr_reg       <= 1'b0;
      ovf_reg        <= 1'b0;
    end else begin
      if (wr_status && hwdata[rcsl_pkg::ST_LINE_BIT]) begin
        line_ready_reg <= 1'b0;
        wr_ptr_reg     <= '0;
      end
      if (wr_status && hwdata[rcsl_pkg::ST_FERR_BIT]) begin
        ferr_reg <= 1'b0;
      end
      if (wr_status && hwdata[rcsl_pkg::ST_OVF_BIT]) begin
        ovf_reg <= 1'b0;
      end
      if (rx_ferr) begin
        ferr_reg <= 1'b1;
      end
      if (rx_valid) begin
        last_ch_reg <= rx_byte;
        if (line_done) begin
          line_ready_reg <= 1'b1;
          line_len_reg   <= 8'(wr_ptr_reg - 1'b1);
        end else if (line_ready_reg
                     || wr_ptr_reg == (IDX_W+1)'(LINE_DEPTH)) begin
          ovf_reg <= 1'b1;
        end else begin
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rx_valid && !line_ready_reg
        && wr_ptr_reg < (IDX_W+1)'(LINE_DEPTH)) begin
      line_mem[wr_ptr_reg[IDX_W-1:0]] <= rx_byte;
    end
  end

  // rts drops early since a host may still send a character or two
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rts_n <= 1'b1;
    end else begin
      rts_n <= line_ready_reg || wr_ptr_reg >=
               (IDX_W+1)'(LINE_DEPTH - rcsl_pkg::RTS_MARGIN);
    end
  end

  // a write while a reply is in flight is dropped; poll the busy bit
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      txseq_reg    <= rcsl_pkg::RCSL_TX_IDLE;
      tx_hold_reg  <= 8'h00;
      tx_eol_reg   <= 1'b0;
      tx_start_reg <= 1'b0;
      tx_byte_reg  <= 8'h00;
    end else begin
      tx_start_reg <= 1'b0;
      case (txseq_reg)
        rcsl_pkg::RCSL_TX_IDLE: begin
          if (wr_tx) begin
            tx_hold_reg <= hwdata[7:0];
            tx_eol_reg  <= hwdata[rcsl_pkg::TX_EOL_BIT];
            txseq_reg   <= rcsl_pkg::RCSL_TX_DATA;
          end
        end
        rcsl_pkg::RCSL_TX_DATA, rcsl_pkg::RCSL_TX_CR,
        rcsl_pkg::RCSL_TX_LF: begin
          // start only while the host asserts clear to send
          if (!tx_busy && !tx_start_reg && !ser_s2_reg[1]) begin
            tx_start_reg <= 1'b1;
            tx_byte_reg  <=
              txseq_reg == rcsl_pkg::RCSL_TX_DATA ? tx_hold_reg :
              txseq_reg == rcsl_pkg::RCSL_TX_CR ? rcsl_pkg::CHAR_CR :
              rcsl_pkg::CHAR_LF;
            if (txseq_reg == rcsl_pkg::RCSL_TX_DATA && tx_eol_reg) begin
              txseq_reg <= rcsl_pkg::RCSL_TX_CR;
            end else if (txseq_reg == rcsl_pkg::RCSL_TX_CR) begin
              txseq_reg <= rcsl_pkg::RCSL_TX_LF;
            end else begin
              txseq_reg <= rcsl_pkg::RCSL_TX_IDLE;
            end
          end
        end
        default: txseq_reg <= rcsl_pkg::RCSL_TX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> design/rcsl_uart.sv
// 8n1 serial transmitter and receiver driven by a 16x baud enable
// assumes rxd is already synchronised and tick16 is a one-cycle pulse
`default_nettype none
module rcsl_uart (
  input  wire logic       sys_clk,    // system clock
  input  wire logic       nrst,       // sync reset, active low
  input  wire logic       tick16,     // 16x baud enable
  input  wire logic       rxd_s,      // synchronised serial input
  input  wire logic       tx_start,   // start one character
  input  wire logic [7:0] tx_byte,    // character to send
  output logic            tx_busy,    // character in flight
  output logic            txd,        // serial output
  output logic            rx_valid,   // one-cycle received strobe
  output logic [7:0]      rx_byte,    // received character
  output logic            rx_ferr     // one-cycle bad stop bit
);
  localparam logic [3:0] TICK_LAST = 4'(rcsl_pkg::OVERSAMPLE - 1);
  localparam logic [3:0] TICK_MID  = 4'(rcsl_pkg::OVERSAMPLE / 2 - 1);
  localparam logic [3:0] BIT_STOP  = 4'(rcsl_pkg::DATA_BITS + 1);

  logic [9:0] tx_shift_reg;
  logic [3:0] tx_tick_reg;
  logic [3:0] tx_bit_reg;
  logic       rx_act_reg;
  logic [3:0] rx_tick_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_shift_reg;

  // frame: start bit, eight data bits lsb first, one stop bit
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tx_busy      <= 1'b0;
      txd          <= 1'b1;
      tx_shift_reg <= 10'h3ff;
      tx_tick_reg  <= 4'h0;
      tx_bit_reg   <= 4'h0;
    end else if (!tx_busy) begin
      if (tx_start) begin
        tx_busy      <= 1'b1;
        tx_shift_reg <= {1'b1, tx_byte, 1'b0};
        tx_tick_reg  <= 4'h0;
        tx_bit_reg   <= 4'h0;
      end
    end else if (tick16) begin
      txd <= tx_shift_reg[0];
      if (tx_tick_reg == TICK_LAST) begin
        tx_tick_reg  <= 4'h0;
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_bit_reg   <= tx_bit_reg + 4'h1;
        if (tx_bit_reg == BIT_STOP) begin
          tx_busy <= 1'b0;
        end
      end else begin
        tx_tick_reg <= tx_tick_reg + 4'h1;
      end
    end
  end

  // receiver samples mid-bit; a stop bit read low is a framing error
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_act_reg   <= 1'b0;
      rx_tick_reg  <= 4'h0;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_valid     <= 1'b0;
      rx_byte      <= 8'h00;
      rx_ferr      <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      rx_ferr  <= 1'b0;
      if (tick16) begin
        if (!rx_act_reg) begin
          if (!rxd_s) begin
            rx_act_reg  <= 1'b1;
            rx_tick_reg <= 4'h0;
            rx_bit_reg  <= 4'h0;
          end
        end else if (rx_tick_reg == TICK_MID && rx_bit_reg == 4'h0) begin
          // false start: line back high at the middle of the start bit
          rx_act_reg  <= !rxd_s;
          rx_bit_reg  <= 4'h1;
          rx_tick_reg <= 4'h0;
        end else if (rx_tick_reg == TICK_LAST) begin
          rx_tick_reg <= 4'h0;
          if (rx_bit_reg == BIT_STOP) begin
            rx_act_reg <= 1'b0;
            rx_valid   <= rxd_s;
            rx_ferr    <= !rxd_s;
            rx_byte    <= rx_shift_reg;
          end else begin
            rx_shift_reg <= {rxd_s, rx_shift_reg[7:1]};
            rx_bit_reg   <= rx_bit_reg + 4'h1;
          end
        end else begin
          rx_tick_reg <= rx_tick_reg + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> pkg/rcsl_pkg.sv
// constants shared by the remote control / serial link block
// assumes a single 125 MHz clock and an AHB-Lite register bus
`default_nettype none
package rcsl_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_STATUS  = 12'h004;
  localparam logic [11:0] OFF_TXDATA  = 12'h008;
  localparam logic [11:0] OFF_KEYS    = 12'h00c;
  localparam logic [11:0] OFF_CALCNT  = 12'h010;
  localparam int          BUF_BIT     = 8;      // addr bit selecting buffer
  // ctrl fields
  localparam int          CTRL_BAUD_LSB = 0;  // 3 bits
  localparam int          CTRL_SRC_LSB  = 3;  // 2 bits
  localparam int          CTRL_COND_BIT = 5;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0002;
  // status fields
  localparam int          ST_MODE_LSB   = 0;  // 2 bits
  localparam int          ST_RUN_BIT    = 2;
  localparam int          ST_LINE_BIT   = 3;
  localparam int          ST_TXBUSY_BIT = 4;
  localparam int          ST_FERR_BIT   = 5;
  localparam int          ST_OVF_BIT    = 6;
  localparam int          ST_LEN_LSB    = 8;  // 8 bits
  // txdata / key fields
  localparam int          TX_EOL_BIT    = 8;
  localparam int          KEY_START_BIT = 0;
  localparam int          KEY_STOP_BIT  = 1;
  localparam int          KEY_PAUSE_BIT = 2;
  localparam int          KEY_CAL_BIT   = 3;
  // baud rates in bits per second, index is the ctrl baud field
  localparam int          BAUD_0 = 1200;
  localparam int          BAUD_1 = 2400;
  localparam int          BAUD_2 = 9600;
  localparam int          BAUD_3 = 19200;
  localparam int          BAUD_4 = 38400;
  localparam int          OVERSAMPLE = 16;
  localparam int          DATA_BITS  = 8;
  localparam logic [7:0]  CHAR_CR = 8'h0d;
  localparam logic [7:0]  CHAR_LF = 8'h0a;
  // bcd source select
  localparam logic [1:0]  SRC_THICKNESS_RESULT = 2'h0;
  localparam logic [1:0]  SRC_GAP_A = 2'h1;
  localparam logic [1:0]  SRC_GAP_B = 2'h2;
  localparam int          RTS_MARGIN = 4;     // free slots left at rts drop
  typedef enum logic [1:0] {
    RCSL_MEASURE,
    RCSL_CALC,
    RCSL_SUSPEND
  } rcsl_mode_t;
  typedef enum logic [1:0] {
    RCSL_TX_IDLE,
    RCSL_TX_DATA,
    RCSL_TX_CR,
    RCSL_TX_LF
  } rcsl_txseq_t;
endpackage
`default_nettype wire

// >>> tb/rcsl_host_model.sv
// host side of the serial link: 8n1 sender and receiver
// assumes the bench sets bit_t to the clocks of one bit
`default_nettype none
module rcsl_host_model (
  input  wire logic sys_clk, // clock
  input  wire logic txd,     // device serial out
  input  wire logic rts_n,   // device accepts, low
  input  wire logic hold,    // bench stalls host
  output var logic  rxd,     // device serial in
  output logic      cts_n    // host ready, low
);
  timeunit 1ns;
  timeprecision 1ps;
  int         bit_t = 64;
  int         ferr = 0;
  logic [7:0] rxq[$];
  logic [7:0] b;
  assign cts_n = hold;
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] c);
    int k;
    while (rts_n !== 1'b0) @(posedge sys_clk);
    for (k = 0; k < 10; k++) begin
      rxd <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : c[k-1];
      repeat (bit_t) @(posedge sys_clk);
    end
  endtask
  always begin
    @(negedge txd);
    repeat (bit_t / 2) @(posedge sys_clk);
    repeat (8) begin
      repeat (bit_t) @(posedge sys_clk);
      b = {txd, b[7:1]};
    end
    repeat (bit_t) @(posedge sys_clk);
    if (txd !== 1'b1) ferr++;
    rxq.push_back(b);
  end
endmodule
`default_nettype wire

// >>> tb/rcsl_top_properties.sv
// port checker for rcsl_top, attached by bind
// assumes a 2-stage sync on every async input
`default_nettype none
module rcsl_top_props (
  input wire logic sys_clk,             // clock
  input wire logic nrst,                // reset, low
  input wire logic hreadyout,           // slave ready
  input wire logic hresp,               // response
  input wire logic remote_start,        // start pin
  input wire logic remote_stop,         // stop pin
  input wire logic running_status,      // running
  input wire logic cal_pulse,           // cal strobe
  input wire logic txd,                 // serial out
  input wire logic cts_n,               // host ready
  input wire logic meas_update,         // new values
  input wire logic parallel_data_valid  // bcd valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  bus_ready_a: assert property (hreadyout)
    else $error("slave not ready");
  bus_okay_a: assert property (!hresp)
    else $error("response not okay");
  reset_idle_a: assert property (disable iff (1'b0) !nrst |=>
    txd && !running_status && !cal_pulse && !parallel_data_valid)
    else $error("outputs not idle in reset");
  cal_once_a: assert property (cal_pulse |=> !cal_pulse)
    else $error("cal pulse too long");
  start_bit_a: assert property ($fell(txd) |=> !txd [*8])
    else $error("start bit too short");
  cts_hold_a: assert property ($fell(txd) |-> !$past(cts_n, 2))
    else $error("sent while host not ready");
  stop_run_a: assert property ($rose(remote_stop) |->
    ##[1:5] !running_status) else $error("stop ignored");
  start_run_a: assert property ($rose(remote_start) &&
    !remote_stop && !running_status |-> ##[1:5] running_status)
    else $error("start ignored");
  bcd_reload_a: assert property (meas_update |=>
    !parallel_data_valid ##1 parallel_data_valid)
    else $error("valid not dropped for reload");
  cover property ($rose(running_status));
  cover property (cal_pulse);
  cover property (meas_update);
endmodule
bind rcsl_top rcsl_top_props u_props (
  .sys_clk(sys_clk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp),
  .remote_start(remote_start), .remote_stop(remote_stop),
  .running_status(running_status), .cal_pulse(cal_pulse), .txd(txd),
  .cts_n(cts_n), .meas_update(meas_update),
  .parallel_data_valid(parallel_data_valid));
`default_nettype wire

// >>> tb/tb.sv
// bench for rcsl_top: bus, remote pins, serial rows, bcd select
// assumes rcsl_host_model stands on the serial side
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, nrst, hsel, hwrite, hold, mu, txd, rxd, cts_n;
  logic        r_go, r_stop, r_pause, r_cal, rts_n, run, dv, hro;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [23:0] bcd;
  int          errors = 0, checks = 0, i;
  int          bt[5] = '{512, 256, 64, 32, 16};
  logic [1:0]  sr[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
  logic [23:0] eb[5] = '{24'h123456, 24'h234567, 24'h345678,
                         24'h123456, 24'h234567};
  logic [7:0]  msg[4] = '{8'h4f, 8'h4b, 8'h0d, 8'h0a};
  rcsl_top #(.CLK_HZ(614400)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hro), .hrdata(hrdata), .hreadyout(hro), .hresp(),
    .remote_start(r_go), .remote_stop(r_stop), .remote_pause(r_pause),
    .reference_calibrate_input(r_cal), .running_status(run),
    .cal_pulse(), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n),
    .thickness_result(24'h123456), .gap_a(24'h234567),
    .gap_b(24'h345678), .meas_update(mu), .bcd_data(bcd),
    .parallel_data_valid(dv));
  rcsl_host_model u_host (.sys_clk(sys_clk), .txd(txd), .rts_n(rts_n),
    .hold(hold), .rxd(rxd), .cts_n(cts_n));
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, a};
    do @(posedge sys_clk); while (hro !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hro !== 1'b1);
    q = hrdata;
  endtask
  task automatic mode(input logic [1:0] m);
    w(6);
    bus(1'b0, 12'h004, 32'h0);
    chk(q[2:0], {m != 2'h0, m});
    chk(run, m != 2'h0);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    stop_test;
  end
  initial begin
    {nrst, hsel, hwrite, hold, mu, r_go, r_stop, r_pause, r_cal} = '0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    w(16);
    nrst <= 1'b1;
    w(2);
    bus(1'b0, 12'h000, 32'h0);
    chk(q, 32'h2);
    chk({txd, rts_n, dv}, 3'h5);
    $display("reset test done");
    for (i = 0; i < 5; i++) begin
      bus(1'b1, 12'h000, {27'h0, sr[i], i[2:0]});
      u_host.bit_t = bt[i];
      w(3);
      chk({dv, bcd}, {1'b1, eb[i]});
      bus(1'b1, 12'h008, 32'h141 + i);
      while (u_host.rxq.size() < 3) @(posedge sys_clk);
      chk({u_host.rxq[0], u_host.rxq[1], u_host.rxq[2]},
          {8'h41 + 8'(i), 8'h0d, 8'h0a});
      u_host.rxq.delete();
      w(bt[i]);
    end
    mu <= 1'b1;
    w(1);
    mu <= 1'b0;
    w(3);
    chk({dv, bcd}, {1'b1, 24'h234567});
    hold <= 1'b1;
    w(4);
    bus(1'b1, 12'h008, 32'h43);
    w(200);
    chk(u_host.rxq.size(), 0);
    hold <= 1'b0;
    while (u_host.rxq.size() < 1) @(posedge sys_clk);
    chk(u_host.rxq.pop_front(), 8'h43);
    chk(u_host.ferr, 0);
    $display("transmit tests done");
    w(32);
    foreach (msg[k]) u_host.send(msg[k]);
    w(8);
    bus(1'b0, 12'h004, 32'h0);
    chk({q[15:8], q[3], rts_n}, {8'h2, 2'h3});
    bus(1'b0, 12'h104, 32'h0);
    chk(q, 32'h4b);
    bus(1'b0, 12'h020, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 12'h004, 32'h8);
    w(4);
    chk(rts_n, 1'b0);
    $display("receive test done");
    bus(1'b1, 12'h000, 32'h22);
    r_go <= 1'b1;
    mode(2'h1);
    r_pause <= 1'b1;
    mode(2'h2);
    r_pause <= 1'b0;
    w(4);
    r_pause <= 1'b1;
    mode(2'h1);
    r_cal <= 1'b1;
    w(6);
    r_cal <= 1'b0;
    r_stop <= 1'b1;
    mode(2'h0);
    r_cal <= 1'b1;
    w(6);
    bus(1'b0, 12'h010, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, 12'h00c, 32'h1);
    mode(2'h1);
    bus(1'b1, 12'h00c, 32'h2);
    mode(2'h0);
    $display("remote test done");
    nrst <= 1'b0;
    w(16);
    nrst <= 1'b1;
    w(2);
    bus(1'b0, 12'h000, 32'h0);
    chk({q, run}, {32'h2, 1'b0});
    stop_test;
  end
endmodule
`default_nettype wire
